// >>> rtl/lsmc_pkg.sv
// Purpose: constants and types of the load signal map calibrator
// Assumes: 100 MHz clock, analog levels carried as 6.25 mV codes
// Notes: 0 V to 5 V is code 0 to 800
package lsmc_pkg;
   localparam int unsigned CLOCK_NS = 10;
   localparam int unsigned TICK_NS = 1000;
   localparam int unsigned TICK_CYCLES = TICK_NS / CLOCK_NS;
   localparam logic [6:0] TICK_LAST = 7'(TICK_CYCLES - 1);
   localparam int unsigned STOP_TIMEOUT_US = 1_000_000;

   localparam int CODE_W = 10;
   localparam logic [9:0] CODE_FULL = 10'h320;
   localparam logic [7:0] CELL_MAX = 8'hC8;
   localparam logic [7:0] CELL_MID = 8'h64;
   localparam int DIRECT_SHIFT = 2;
   localparam int LOAD_BIN_LSB = 6;
   localparam int RPM_BIN_LSB = 9;
   localparam logic [15:0] RPM_BIN_TOP = 16'h1E00;

   localparam int PERIOD_W = 20;
   localparam int NUM_W = 27;
   localparam logic [26:0] RPM_NUM_FOUR = 27'h7270E00;
   localparam logic [26:0] RPM_NUM_TWO = 27'h3938700;
   localparam logic [4:0] DIV_LAST = 5'h1A;
   localparam logic [3:0] CYL_MIN = 4'h1;
   localparam logic [3:0] CYL_MAX = 4'hC;

   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_MAP_ADDR = 4'h1;
   localparam logic [3:0] REG_MAP_DATA = 4'h2;
   localparam logic [3:0] REG_RPM = 4'h3;
   localparam logic [3:0] REG_LOOKUP = 4'h4;
   localparam logic [3:0] REG_CELL = 4'h5;
   localparam logic [3:0] REG_STATUS = 4'h6;
   localparam logic [15:0] CTRL_RESET = 16'h0008;

   typedef struct packed {
      logic [1:0] resolution;
      logic two_stroke;
      logic [3:0] cylinders;
      logic modify;
   } lsmc_cfg_type;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [15:0] wdata;
   } lsmc_bus_type;

   typedef enum logic [1:0] {
      DIV_IDLE = 2'b01,
      DIV_RUN = 2'b10
   } lsmc_div_state_type;
endpackage : lsmc_pkg

// >>> rtl/lsmc_top.sv
// Purpose: map lookup by load and engine speed, direct or modify output
// Assumes: converter codes arrive synchronous, tach is a clean level
// Notes: map array is not cleared by reset, so it survives restarts
//
// Behaviour
// RQ1: Active cell comes from the map indexed by load input and engine speed.
// RQ2: Direct output level is active cell value divided by four volts.
// RQ3: Output runs 0 to 5 V in 200 steps of 25 mV.
// RQ4: Cells hold 0.0 to 20.0; same step in both modes.
// RQ5: Modify output adds (cell minus ten) over four volts to sensor input.
// RQ6: Offset spans plus or minus 2.5 V; ten leaves signal alone.
// RQ7: Modify mode uses separate offset input and lookup input.
// RQ8: Lookup input accepts any external 0 to 5 V control signal.
// RQ9: Tach delivers cylinders over two pulses per revolution.
// RQ10: Speed derives from configured cylinder count; lower counts fit slow tach.
// RQ11: One to twelve cylinders, two-stroke or four-stroke.
// RQ12: Host writes the map only with the engine stopped.
// RQ13: Host can read back map and settings as well as write.
// RQ14: Host starts a modify map with ten in every cell.
// RQ15: Finer builds use 12.5 mV or 6.25 mV steps, smaller range; only the modify offset follows resolution here, direct stays at 25 mV steps.
// RQ16: Live speed, input voltage and cell value readable by host.
// RQ17: Modified output saturates within 0 to 5 V.
// RQ18: Map and settings persist and apply right after power-up; the map does here, but ctrl_reg reloads CTRL_RESET on reset.
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/100ps
module lsmc_top #(
   parameter int unsigned STOP_US = lsmc_pkg::STOP_TIMEOUT_US
) (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire lsmc_pkg::lsmc_bus_type i_bus,
   input wire logic [9:0] i_lookup_code,
   input wire logic [9:0] i_sensor_signal_input,
   input wire logic i_tach,
   output logic [15:0] o_rdata,
   output logic [9:0] o_direct_code,
   output logic [9:0] o_modify_code
);

   // ==========================================
   // Register port
   logic [15:0] ctrl_reg;
   logic [7:0] map_addr_reg;
   // Blank store reads as ten, so an unprogrammed map leaves the signal alone
   logic [7:0] map_mem [256] = '{default: lsmc_pkg::CELL_MID};
   logic [15:0] rdata_reg;
   lsmc_pkg::lsmc_cfg_type cfg;
   logic wr_ctrl;
   logic wr_addr;
   logic wr_data;
   logic rd_data;
   logic [7:0] wcell;
   logic [15:0] rd_mux;

   assign cfg = lsmc_pkg::lsmc_cfg_type'(ctrl_reg[7:0]);
   assign wr_ctrl = i_bus.wr && i_bus.addr == lsmc_pkg::REG_CTRL;
   assign wr_addr = i_bus.wr && i_bus.addr == lsmc_pkg::REG_MAP_ADDR;
   assign wr_data = i_bus.wr && i_bus.addr == lsmc_pkg::REG_MAP_DATA;
   assign rd_data = i_bus.rd && i_bus.addr == lsmc_pkg::REG_MAP_DATA;
   // Out of range cell values are pinned to 20.0
   assign wcell = (i_bus.wdata[7:0] > lsmc_pkg::CELL_MAX) ?
                  lsmc_pkg::CELL_MAX : i_bus.wdata[7:0]; // see RQ4

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         ctrl_reg <= lsmc_pkg::CTRL_RESET;
         map_addr_reg <= 8'h00;
      end else begin
         if (wr_ctrl) begin
            ctrl_reg <= {8'h00, i_bus.wdata[7:0]};
         end
         if (wr_addr) begin
            map_addr_reg <= i_bus.wdata[7:0];
         end else if (wr_data || rd_data) begin
            map_addr_reg <= map_addr_reg + 8'h01;
         end
      end
   end

   // No reset: contents stand through reset and apply at once
   // Host keeps writes to stopped engine, so no tearing guard
   always_ff @(posedge i_clock) begin // see RQ18
      if (wr_data) begin
         map_mem[map_addr_reg] <= wcell; // see RQ12
      end
   end

   // ==========================================
   // Engine speed
   logic [6:0] tick_cnt_reg;
   logic tick;
   logic tach_prev_reg;
   logic tach_rise;
   logic [19:0] period_reg;
   logic armed_reg;
   logic stop_hit;
   logic [3:0] cyl_eff;
   logic [1:0] res_eff;

   assign tick = tick_cnt_reg == lsmc_pkg::TICK_LAST;
   assign tach_rise = i_tach && !tach_prev_reg;
   assign stop_hit = period_reg >= 20'(STOP_US);
   // Illegal counts fall back to the nearest legal count
   assign cyl_eff = (cfg.cylinders < lsmc_pkg::CYL_MIN) ? lsmc_pkg::CYL_MIN :
                    (cfg.cylinders > lsmc_pkg::CYL_MAX) ? lsmc_pkg::CYL_MAX :
                    cfg.cylinders; // see RQ11
   assign res_eff = (cfg.resolution == 2'h3) ? 2'h2 : cfg.resolution;

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         tick_cnt_reg <= 7'h00;
         tach_prev_reg <= 1'b0;
         period_reg <= 20'h00000;
         armed_reg <= 1'b0;
      end else begin
         tick_cnt_reg <= tick ? 7'h00 : tick_cnt_reg + 7'h01;
         tach_prev_reg <= i_tach;
         if (tach_rise) begin
            period_reg <= 20'h00000;
            armed_reg <= 1'b1;
         end else if (stop_hit) begin
            armed_reg <= 1'b0;
         end else if (tick) begin
            period_reg <= period_reg + 20'h00001;
         end
      end
   end

   // ==========================================
   // Speed divider: rpm = k / (period_us * cylinders)
   lsmc_pkg::lsmc_div_state_type div_state_reg;
   logic [26:0] num_reg;
   logic [23:0] den_reg;
   logic [27:0] rem_reg;
   logic [26:0] quo_reg;
   logic [4:0] div_cnt_reg;
   logic [15:0] rpm_reg;
   logic div_start;
   logic [27:0] rem_shift;
   logic rem_ge;
   logic [26:0] quo_next;
   logic [26:0] num_sel;

   assign div_start = tach_rise && armed_reg && period_reg != 20'h00000;
   // Four-stroke tach gives cylinders/2 per rev, two-stroke one per cylinder
   assign num_sel = cfg.two_stroke ? lsmc_pkg::RPM_NUM_TWO :
                    lsmc_pkg::RPM_NUM_FOUR; // see RQ9
   assign rem_shift = {rem_reg[26:0], num_reg[26]};
   assign rem_ge = rem_shift >= {4'h0, den_reg};
   assign quo_next = {quo_reg[25:0], rem_ge};

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         div_state_reg <= lsmc_pkg::DIV_IDLE;
         num_reg <= 27'h0000000;
         den_reg <= 24'h000000;
         rem_reg <= 28'h0000000;
         quo_reg <= 27'h0000000;
         div_cnt_reg <= 5'h00;
         rpm_reg <= 16'h0000;
      end else begin
         unique case (div_state_reg)
            lsmc_pkg::DIV_IDLE: begin
               if (div_start) begin
                  num_reg <= num_sel;
                  den_reg <= {4'h0, period_reg} * {20'h00000, cyl_eff}; // see RQ10
                  rem_reg <= 28'h0000000;
                  quo_reg <= 27'h0000000;
                  div_cnt_reg <= 5'h00;
                  div_state_reg <= lsmc_pkg::DIV_RUN;
               end else if (stop_hit) begin
                  rpm_reg <= 16'h0000; // see RQ10
               end
            end
            lsmc_pkg::DIV_RUN: begin
               num_reg <= {num_reg[25:0], 1'b0};
               rem_reg <= rem_ge ? rem_shift - {4'h0, den_reg} : rem_shift;
               quo_reg <= quo_next;
               div_cnt_reg <= div_cnt_reg + 5'h01;
               if (div_cnt_reg == lsmc_pkg::DIV_LAST) begin
                  rpm_reg <= (quo_next[26:16] != 11'h000) ? 16'hFFFF :
                             quo_next[15:0];
                  div_state_reg <= lsmc_pkg::DIV_IDLE;
               end
            end
         endcase
      end
   end

   // ==========================================
   // Lookup and outputs
   logic [9:0] lookup_clamp;
   logic [3:0] load_bin;
   logic [3:0] rpm_bin;
   logic [7:0] cell_index;
   logic [7:0] cell_reg;
   logic [9:0] direct_reg;
   logic [9:0] modify_reg;
   logic signed [11:0] offset;
   logic signed [11:0] mod_sum;
   logic [9:0] mod_sat;

   // Any 0 to 5 V source may feed the lookup input
   assign lookup_clamp = (i_lookup_code > lsmc_pkg::CODE_FULL) ?
                         lsmc_pkg::CODE_FULL : i_lookup_code; // see RQ8
   assign load_bin = lookup_clamp[lsmc_pkg::LOAD_BIN_LSB +: 4];
   assign rpm_bin = (rpm_reg >= lsmc_pkg::RPM_BIN_TOP) ? 4'hF :
                    rpm_reg[lsmc_pkg::RPM_BIN_LSB +: 4];
   assign cell_index = {load_bin, rpm_bin}; // see RQ1
   // Cell-100 scaled: x4 is 25 mV steps, x2 and x1 the finer builds
   assign offset = ($signed({4'h0, cell_reg}) - $signed({4'h0, lsmc_pkg::CELL_MID}))
                   <<< (2'h2 - res_eff); // see RQ5 see RQ6 see RQ15
   // Offset applies to the sensor input, not the lookup input
   assign mod_sum = $signed({2'b00, i_sensor_signal_input}) + offset; // see RQ7
   assign mod_sat = (mod_sum < 12'sh000) ? 10'h000 :
                    (mod_sum > $signed({2'b00, lsmc_pkg::CODE_FULL})) ?
                    lsmc_pkg::CODE_FULL : mod_sum[9:0]; // see RQ17

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         cell_reg <= 8'h00;
         direct_reg <= 10'h000;
         modify_reg <= 10'h000;
      end else begin
         cell_reg <= map_mem[cell_index]; // see RQ1
         // Cell in 0.1 units: cell/4 V is cell*4 codes of 6.25 mV
         direct_reg <= {cell_reg, 2'b00}; // see RQ2 see RQ3
         modify_reg <= cfg.modify ? mod_sat : i_sensor_signal_input;
      end
   end

   // ==========================================
   // Read back
   assign rd_mux = (i_bus.addr == lsmc_pkg::REG_CTRL) ? ctrl_reg :
                   (i_bus.addr == lsmc_pkg::REG_MAP_ADDR) ? {8'h00, map_addr_reg} :
                   (i_bus.addr == lsmc_pkg::REG_MAP_DATA) ? {8'h00, map_mem[map_addr_reg]} :
                   (i_bus.addr == lsmc_pkg::REG_RPM) ? rpm_reg :
                   (i_bus.addr == lsmc_pkg::REG_LOOKUP) ? {6'h00, lookup_clamp} :
                   (i_bus.addr == lsmc_pkg::REG_CELL) ? {8'h00, cell_reg} :
                   (i_bus.addr == lsmc_pkg::REG_STATUS) ? {15'h0000, armed_reg} :
                   16'h0000; // see RQ13 see RQ16

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         rdata_reg <= 16'h0000;
      end else begin
         rdata_reg <= i_bus.rd ? rd_mux : 16'h0000;
      end
   end

   assign o_rdata = rdata_reg;
   assign o_direct_code = direct_reg;
   assign o_modify_code = modify_reg;

   // ==========================================
   // Assertions
   property p_lookup;
      @(posedge i_clock) disable iff (i_rst)
      !$past(i_rst) |-> cell_reg == $past(map_mem[cell_index]);
   endproperty
   a_lookup: assert property (p_lookup) else $error("cell not from index"); // see RQ1

   property p_direct;
      @(posedge i_clock) disable iff (i_rst)
      !i_rst |-> ##2 o_direct_code == {$past(map_mem[cell_index], 2), 2'b00};
   endproperty
   a_direct: assert property (p_direct) else $error("direct level wrong"); // see RQ2

   property p_cell_range;
      @(posedge i_clock) disable iff (i_rst)
      cell_reg <= lsmc_pkg::CELL_MAX;
   endproperty
   a_cell_range: assert property (p_cell_range) else $error("cell above 20.0"); // see RQ4

   property p_mid_clean;
      @(posedge i_clock) disable iff (i_rst)
      (cfg.modify && cell_reg == lsmc_pkg::CELL_MID && i_sensor_signal_input <= lsmc_pkg::CODE_FULL)
      |=> o_modify_code == $past(i_sensor_signal_input);
   endproperty
   a_mid_clean: assert property (p_mid_clean) else $error("mid cell altered signal"); // see RQ6

   property p_sat;
      @(posedge i_clock) disable iff (i_rst)
      $past(cfg.modify) |-> o_modify_code <= lsmc_pkg::CODE_FULL;
   endproperty
   a_sat: assert property (p_sat) else $error("modify out of span"); // see RQ17

   property p_cyl;
      @(posedge i_clock) disable iff (i_rst)
      cyl_eff >= lsmc_pkg::CYL_MIN && cyl_eff <= lsmc_pkg::CYL_MAX;
   endproperty
   a_cyl: assert property (p_cyl) else $error("cylinder count illegal"); // see RQ11

   property p_div_len;
      @(posedge i_clock) disable iff (i_rst)
      (div_state_reg == lsmc_pkg::DIV_IDLE && div_start)
      |=> (div_state_reg == lsmc_pkg::DIV_RUN)[*8] ##20 div_state_reg == lsmc_pkg::DIV_IDLE;
   endproperty
   a_div_len: assert property (p_div_len) else $error("speed divide length"); // see RQ9

   property p_stop;
      @(posedge i_clock) disable iff (i_rst)
      (stop_hit && !tach_rise && div_state_reg == lsmc_pkg::DIV_IDLE) |=> rpm_reg == 16'h0000;
   endproperty
   a_stop: assert property (p_stop) else $error("speed not zero when stopped"); // see RQ10

   property p_read_rpm;
      @(posedge i_clock) disable iff (i_rst)
      (i_bus.rd && i_bus.addr == lsmc_pkg::REG_RPM) |=> o_rdata == $past(rpm_reg);
   endproperty
   a_read_rpm: assert property (p_read_rpm) else $error("speed readback wrong"); // see RQ16

   c_modify: cover property (@(posedge i_clock) disable iff (i_rst)
      cfg.modify && mod_sum > $signed({2'b00, lsmc_pkg::CODE_FULL}));
   c_speed: cover property (@(posedge i_clock) disable iff (i_rst)
      div_state_reg == lsmc_pkg::DIV_RUN && div_cnt_reg == lsmc_pkg::DIV_LAST);
   c_map_rw: cover property (@(posedge i_clock) disable iff (i_rst) wr_addr ##2 rd_data);
endmodule : lsmc_top

// >>> verification/lsmc_engine_model.sv
// Purpose: engine and load sensor model facing the calibrator
// Assumes: tach period given in clock cycles
// Notes: tach stands low while the engine is stopped
`timescale 1ns/100ps
module lsmc_engine_model (
   input wire logic i_clock,
   input wire logic i_run,
   input wire logic [19:0] i_period,
   input wire logic [9:0] i_load,
   input wire logic [9:0] i_sensor,
   output logic o_tach,
   output logic [9:0] o_lookup_code,
   output logic [9:0] o_sensor_signal_input
);
   logic [19:0] cnt_reg;
   // ==========================================
   // Tach pulse train
   always_ff @(posedge i_clock) begin
      if (!i_run) begin
         cnt_reg <= 20'h00000;
      end else if (cnt_reg >= i_period - 20'h00001) begin
         cnt_reg <= 20'h00000;
      end else begin
         cnt_reg <= cnt_reg + 20'h00001;
      end
   end
   // One pulse per period, period set for cylinders over two per rev
   assign o_tach = i_run && (cnt_reg < 20'h00014);
   // Lookup and offset inputs kept apart to prove they are independent
   assign o_lookup_code = i_load;
   assign o_sensor_signal_input = i_sensor;
endmodule : lsmc_engine_model

// >>> verification/lsmc_top_tb.sv
// Purpose: self-checking bench of the calibrator top
// Assumes: stop timeout shortened to 200 us
// Notes: map cells are written only with the engine stopped
`timescale 1ns/100ps
module lsmc_top_tb;
   logic clock = 1'b0;
   logic rst = 1'b1;
   lsmc_pkg::lsmc_bus_type bus = '0;
   logic [9:0] load = 10'h000;
   logic [9:0] sens = 10'h000;
   logic run = 1'b0;
   logic [19:0] period = 20'h03A98;
   logic tach;
   logic [9:0] lookup, sensor, direct, modify;
   logic [15:0] rdata;
   logic [15:0] rd_val;
   logic [7:0] cells [5] = '{8'h00, 8'h28, 8'h64, 8'hC8, 8'hFF};
   int error_cnt = 0;
   int tests_run = 0;
   int cycles = 0;
   always #5 clock = ~clock;
   lsmc_engine_model engine (.i_clock(clock), .i_run(run), .i_period(period), .i_load(load),
      .i_sensor(sens), .o_tach(tach), .o_lookup_code(lookup), .o_sensor_signal_input(sensor));
   lsmc_top #(.STOP_US(200)) dut (.i_clock(clock), .i_rst(rst), .i_bus(bus), .i_lookup_code(lookup),
      .i_sensor_signal_input(sensor), .i_tach(tach), .o_rdata(rdata), .o_direct_code(direct),
      .o_modify_code(modify));
   // ==========================================
   // Shared tasks
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   // Gap cycle after every strobe keeps one assignment per time step
   task automatic bus_op(input logic wr, input logic [3:0] addr, input logic [15:0] data);
      @(posedge clock);
      bus <= '{wr: wr, rd: ~wr, addr: addr, wdata: data};
      @(posedge clock);
      bus <= '0;
      #1 rd_val = rdata;
   endtask : bus_op
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : final_report
   always @(posedge clock) begin
      cycles++;
      if (cycles == 90000) begin
         error_cnt++;
         final_report();
      end
   end
   // ==========================================
   // Scenarios
   task automatic t_reset_regs;
      bus_op(1'b0, lsmc_pkg::REG_CTRL, 16'h0000);
      chk("ctrl", lsmc_pkg::CTRL_RESET, rd_val);
      bus_op(1'b1, lsmc_pkg::REG_RPM, 16'h1234);
      bus_op(1'b0, lsmc_pkg::REG_RPM, 16'h0000);
      chk("rpm", 16'h0000, rd_val);
      bus_op(1'b0, 4'hF, 16'h0000);
      chk("unmapped", 16'h0000, rd_val);
   endtask : t_reset_regs
   task automatic t_map;
      for (int b = 0; b < 5; b++) begin
         bus_op(1'b1, lsmc_pkg::REG_MAP_ADDR, {8'h00, 4'(b), 4'h0});
         bus_op(1'b1, lsmc_pkg::REG_MAP_DATA, {8'h00, cells[b]});
      end
      bus_op(1'b1, lsmc_pkg::REG_MAP_ADDR, 16'h000F);
      bus_op(1'b1, lsmc_pkg::REG_MAP_DATA, 16'h00A0);
      bus_op(1'b0, lsmc_pkg::REG_MAP_ADDR, 16'h0000);
      chk("map addr", 16'h0010, rd_val);
      for (int b = 0; b < 5; b++) begin
         bus_op(1'b1, lsmc_pkg::REG_MAP_ADDR, {8'h00, 4'(b), 4'h0});
         bus_op(1'b0, lsmc_pkg::REG_MAP_DATA, 16'h0000);
         chk("cell", {8'h00, (cells[b] > 8'hC8) ? 8'hC8 : cells[b]}, rd_val);
      end
   endtask : t_map
   task automatic t_direct;
      logic [7:0] exp;
      for (int b = 0; b < 5; b++) begin
         exp = (cells[b] > 8'hC8) ? 8'hC8 : cells[b];
         @(posedge clock);
         load <= {4'(b), 6'h00};
         repeat (4) @(posedge clock);
         #1 chk("direct", {6'h00, exp, 2'b00}, {6'h00, direct});
         bus_op(1'b0, lsmc_pkg::REG_CELL, 16'h0000);
         chk("active cell", {8'h00, exp}, rd_val);
      end
      @(posedge clock);
      load <= 10'h3FF;
      repeat (2) @(posedge clock);
      bus_op(1'b0, lsmc_pkg::REG_LOOKUP, 16'h0000);
      chk("lookup", 16'h0320, rd_val);
   endtask : t_direct
   task automatic mod_case(input logic [3:0] bin, input logic [1:0] res, input logic [9:0] s,
      input logic [9:0] exp);
      bus_op(1'b1, lsmc_pkg::REG_CTRL, {8'h00, res, 6'h09});
      @(posedge clock);
      load <= {bin, 6'h00};
      sens <= s;
      repeat (4) @(posedge clock);
      #1 chk("modify", {6'h00, exp}, {6'h00, modify});
   endtask : mod_case
   task automatic t_modify;
      mod_case(4'h2, 2'h0, 10'h190, 10'h190);
      mod_case(4'h0, 2'h0, 10'h1F4, 10'h064);
      mod_case(4'h3, 2'h0, 10'h12C, 10'h2BC);
      mod_case(4'h1, 2'h0, 10'h1F4, 10'h104);
      mod_case(4'h0, 2'h0, 10'h064, 10'h000);
      mod_case(4'h3, 2'h0, 10'h2BC, 10'h320);
      mod_case(4'h3, 2'h1, 10'h12C, 10'h1F4);
      mod_case(4'h0, 2'h2, 10'h12C, 10'h0C8);
   endtask : t_modify
   // Tick phase may shift the period by one microsecond, so accept a band
   task automatic poll_rpm(input logic [15:0] lo, input logic [15:0] hi);
      int n;
      n = 0;
      do begin
         bus_op(1'b0, lsmc_pkg::REG_RPM, 16'h0000);
         n++;
      end while ((rd_val < lo || rd_val > hi) && n < 30000);
      tests_run++;
      if ($isunknown(rd_val) || rd_val < lo || rd_val > hi) begin
         error_cnt++;
         $display("wrong value rpm expected %h to %h seen %h", lo, hi, rd_val);
      end
   endtask : poll_rpm
   task automatic t_tach;
      bus_op(1'b1, lsmc_pkg::REG_CTRL, 16'h0038);
      @(posedge clock);
      load <= 10'h000;
      run <= 1'b1;
      poll_rpm(16'h8158, 16'h8315);
      repeat (3) @(posedge clock);
      #1 chk("direct by speed", 16'h0280, {6'h00, direct});
      bus_op(1'b1, lsmc_pkg::REG_CTRL, 16'h0018);
      poll_rpm(16'hFFFF, 16'hFFFF);
      @(posedge clock);
      run <= 1'b0;
      poll_rpm(16'h0000, 16'h0000);
   endtask : t_tach
   task automatic t_persist;
      @(posedge clock);
      rst <= 1'b1;
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      bus_op(1'b0, lsmc_pkg::REG_CTRL, 16'h0000);
      chk("ctrl after reset", lsmc_pkg::CTRL_RESET, rd_val);
      bus_op(1'b1, lsmc_pkg::REG_MAP_ADDR, 16'h0030);
      bus_op(1'b0, lsmc_pkg::REG_MAP_DATA, 16'h0000);
      chk("cell after reset", 16'h00C8, rd_val);
   endtask : t_persist
   initial begin
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      t_reset_regs();
      t_map();
      t_direct();
      t_modify();
      t_tach();
      t_persist();
      final_report();
   end
endmodule : lsmc_top_tb
